/* logic/ftsc_flash_ctrl.sv */
/*
  Flash trigger and sense control: trigger input handling (edge or level
  mode) with timed pulse, open-drain charge-done flag, three-region sense
  scaleback, indicator switch, charge-pump gain stepping, shutdown control
  and a small register file with interrupts.
  Assumes: trigger and comparator inputs come from pins (synchronised here);
  capacitor comparator levels arrive as digital flags from the analog side.
*/
// Implementation choices: the placing of the registers and the strobed register port.
// Behaviour
// - Reset default: rising-edge trigger starts timed flash
// - Pulse length from options bits 3:0
// - Options bit 7 selects level-sensitive trigger
// - Level mode: flash while trigger held high
// - Level mode: duration expiry turns flash off
// - Charge-done flag rests high, low at target
// - Flag is open-drain, drives only low
// - Flag releases below 95 percent target
// - Two comparators classify sense into regions
// - Low region allows full flash current
// - Middle region limits current to 70 percent
// - High region blocks every flash request
// - General bit 6 enables sense scaleback
// - General bit 7 switches indicator source
// - Charging steps pump gain 1x,1.5x,2x
// - Flash entered by register or trigger
// - Shutdown when trigger low, no flash running and bits clear
`timescale 1ns/1ps
module ftsc_flash_ctrl
  import ftsc_pkg::*;
#(
  parameter int unsigned STEP_CYCLES = DUR_STEP_CYCLES
) (
  input  wire logic       mclk,
  input  wire logic       nrst,
  input  wire logic [3:0] regAddr,
  input  wire logic [7:0] regWdata,
  input  wire logic       regWr,
  input  wire logic       regRd,
  output logic      [7:0] regRdata,
  input  wire logic       triggerIn,
  input  wire logic       senseAboveHi,
  input  wire logic       senseAboveLo,
  input  wire logic       capAtTarget,
  input  wire logic       capAbove95,
  output logic            chargeDoneOut,
  output logic            chargeDoneOe,
  output logic            flashOn,
  output logic      [6:0] flashScalePct,
  output logic            indicatorCurrentOut,
  output logic      [1:0] pumpGain,
  output logic            shutdown,
  output logic            irq
);

  ftsc_bus_type bus;
  assign bus = '{addr: regAddr, wdata: regWdata, wr: regWr, rd: regRd};

  logic [7:0] options_q, general_q, senseHi_q, senseLo_q, intEn_q;
  logic [ST_W-1:0] status_q;
  logic [7:0] rdata_q;

  // Pin synchronisers; first stage read only by the second
  logic [4:0] sync1_q, sync2_q;
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      sync1_q <= 5'h00;
      sync2_q <= 5'h00;
    end else begin
      sync1_q <= {capAbove95, capAtTarget, senseAboveLo, senseAboveHi, triggerIn};
      sync2_q <= sync1_q;
    end
  end
  logic trig, aboveHi, aboveLo, atTarget, above95;
  assign {above95, atTarget, aboveLo, aboveHi, trig} = sync2_q;

  logic trigPrev_q;
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) trigPrev_q <= 1'b0;
    else trigPrev_q <= trig;
  end
  logic trigRise;
  assign trigRise = trig & ~trigPrev_q;

  // Sense region classification
  ftsc_region_type region;
  logic senseEn;
  assign senseEn = general_q[GP_SENSE_BIT];
  always_comb begin
    if (aboveHi) region = REGION_HIGH;
    else if (aboveLo) region = REGION_MID;
    else region = REGION_LOW;
  end
  logic flashBlocked;
  assign flashBlocked = senseEn && (region == REGION_HIGH);

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) flashScalePct <= 7'h64;
    else if (senseEn && region == REGION_MID) flashScalePct <= 7'(SCALE_MID_PERCENT);
    else flashScalePct <= 7'h64;
  end

  // Flash sequencing
  logic levelMode;
  assign levelMode = options_q[OPT_LEVEL_BIT];
  logic [OPT_DUR_W-1:0] durSteps;
  assign durSteps = options_q[OPT_DUR_LSB +: OPT_DUR_W];

  logic regFlashReq;
  assign regFlashReq = bus.wr && bus.addr == ADDR_GENERAL
                       && bus.wdata[GP_FLASH_BIT] && !general_q[GP_FLASH_BIT];

  logic        flash_q;
  logic        regFlash_q;
  logic [31:0] cyc_q;
  logic [4:0]  steps_q;
  logic        expired;
  // True in the last cycle, so a pulse lasts exactly (duration + 1) steps
  assign expired = (steps_q == {1'b0, durSteps}) && (cyc_q == STEP_CYCLES - 1);

  logic startReq, evFlashDone, evTimeout, evBlocked;
  // Either mode: only trigger edges or a register flash request while idle start a pulse
  assign startReq = (!levelMode && trigRise) || (levelMode && trigRise)
                    || regFlashReq;
  assign evBlocked = startReq && !flash_q && flashBlocked;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      flash_q    <= 1'b0;
      regFlash_q <= 1'b0;
      cyc_q      <= 32'h0;
      steps_q    <= 5'h00;
    end else if (!flash_q) begin
      cyc_q   <= 32'h0;
      steps_q <= 5'h00;
      if (startReq && !flashBlocked) begin
        flash_q    <= 1'b1;
        regFlash_q <= regFlashReq;
      end
    end else begin
      // Further edges ignored while a pulse runs
      if (cyc_q == STEP_CYCLES - 1) begin
        cyc_q   <= 32'h0;
        steps_q <= steps_q + 5'h01;
      end else begin
        cyc_q <= cyc_q + 32'h1;
      end
      if (flashBlocked) flash_q <= 1'b0;
      else if (levelMode && !regFlash_q && !trig) flash_q <= 1'b0;
      else if (expired) flash_q <= 1'b0;
    end
  end
  assign flashOn = flash_q;
  assign evFlashDone = flash_q && !levelMode && expired;
  assign evTimeout = flash_q && levelMode && trig && expired && !regFlash_q;

  // Charge-done flag: open drain, pulls low only when charged
  logic eoc_q;
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) eoc_q <= 1'b0;
    else if (!above95) eoc_q <= 1'b0;
    else if (atTarget) eoc_q <= 1'b1;
  end
  assign chargeDoneOut = 1'b0;
  assign chargeDoneOe  = eoc_q;

  assign indicatorCurrentOut = general_q[GP_IND_BIT];

  // Charge pump gain stepping while charging
  logic charging;
  assign charging = general_q[GP_CHARGE_BIT] && !atTarget && !flash_q;
  ftsc_gain_type gain_q;
  logic [7:0] gainCnt_q;
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      gain_q    <= GAIN_1X;
      gainCnt_q <= 8'h00;
    end else if (!charging) begin
      gain_q    <= GAIN_1X;
      gainCnt_q <= 8'h00;
    end else begin
      gainCnt_q <= gainCnt_q + 8'h01;
      if (gainCnt_q == 8'hFF) begin
        unique case (gain_q)
          GAIN_1X:   gain_q <= GAIN_1P5X;
          GAIN_1P5X: gain_q <= GAIN_2X;
          GAIN_2X:   gain_q <= GAIN_2X;
          default:   gain_q <= GAIN_1X;
        endcase
      end
    end
  end
  assign pumpGain = gain_q;

  assign shutdown = !trig && !flash_q && !general_q[GP_FLASH_BIT]
                    && !general_q[GP_TORCH_BIT] && !general_q[GP_CHARGE_BIT];

  // Register file, one process per register
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) options_q <= OPTIONS_RST;
    else if (bus.wr && bus.addr == ADDR_OPTIONS) options_q <= bus.wdata;
  end
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) senseHi_q <= SENSE_HI_RST;
    else if (bus.wr && bus.addr == ADDR_SENSE_HI) senseHi_q <= bus.wdata;
  end
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) senseLo_q <= SENSE_LO_RST;
    else if (bus.wr && bus.addr == ADDR_SENSE_LO) senseLo_q <= bus.wdata;
  end
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) intEn_q <= INT_EN_RST;
    else if (bus.wr && bus.addr == ADDR_INT_EN) intEn_q <= bus.wdata;
  end
  // Flash request bit clears itself once its pulse is over or was refused
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) general_q <= GENERAL_RST;
    else if (bus.wr && bus.addr == ADDR_GENERAL) general_q <= bus.wdata;
    else if (!flash_q && general_q[GP_FLASH_BIT]) general_q[GP_FLASH_BIT] <= 1'b0;
  end

  // Sticky status; a new event wins over a clear in the same cycle
  logic [ST_W-1:0] events;
  logic eocPrev_q;
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) eocPrev_q <= 1'b0;
    else eocPrev_q <= eoc_q;
  end
  assign events = {eoc_q & ~eocPrev_q, evBlocked, evTimeout, evFlashDone};
  logic [ST_W-1:0] clrMask;
  assign clrMask = (bus.wr && bus.addr == ADDR_INT_CLR) ? bus.wdata[ST_W-1:0] : '0;
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) status_q <= '0;
    else status_q <= (status_q & ~clrMask) | events;
  end
  assign irq = |(status_q & intEn_q[ST_W-1:0]);

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) rdata_q <= 8'h00;
    else if (bus.rd) begin
      unique case (bus.addr)
        ADDR_OPTIONS:  rdata_q <= options_q;
        ADDR_GENERAL:  rdata_q <= general_q;
        ADDR_SENSE_HI: rdata_q <= senseHi_q;
        ADDR_SENSE_LO: rdata_q <= senseLo_q;
        ADDR_STATUS:   rdata_q <= {4'h0, status_q};
        ADDR_INT_EN:   rdata_q <= intEn_q;
        ADDR_LIVE:     rdata_q <= {flash_q, eoc_q, shutdown, 1'b0, region, gain_q};
        default:       rdata_q <= 8'h00;
      endcase
    end else rdata_q <= 8'h00;
  end
  assign regRdata = rdata_q;

  // Assertions
  flag_drive_a: assert property (@(posedge mclk) disable iff (!nrst)
    $rose(chargeDoneOe) |-> $past(atTarget) && $past(above95) && !chargeDoneOut)
    else $error("flag pulled without charge");

  flag_set_a: assert property (@(posedge mclk) disable iff (!nrst)
    atTarget && above95 |=> chargeDoneOe)
    else $error("flag not asserted at target");

  flag_hold_a: assert property (@(posedge mclk) disable iff (!nrst)
    chargeDoneOe && above95 |=> chargeDoneOe)
    else $error("flag dropped while charged");

  flag_release_a: assert property (@(posedge mclk) disable iff (!nrst)
    !above95 |=> !chargeDoneOe)
    else $error("flag held below threshold");

  high_block_a: assert property (@(posedge mclk) disable iff (!nrst)
    flashBlocked |=> !flash_q)
    else $error("flash in high region");

  blocked_flag_a: assert property (@(posedge mclk) disable iff (!nrst)
    evBlocked |=> status_q[ST_BLOCKED] && !flash_q)
    else $error("blocked request not recorded");

  mid_scale_a: assert property (@(posedge mclk) disable iff (!nrst)
    senseEn && region == REGION_MID |=> flashScalePct == 7'(SCALE_MID_PERCENT))
    else $error("no scaleback");

  low_full_a: assert property (@(posedge mclk) disable iff (!nrst)
    region == REGION_LOW |=> flashScalePct == 7'h64)
    else $error("low region scaled");

  sense_off_a: assert property (@(posedge mclk) disable iff (!nrst)
    !senseEn |=> flashScalePct == 7'h64)
    else $error("scaled while sensing off");

  sense_read_a: assert property (@(posedge mclk) disable iff (!nrst)
    regRd && regAddr == ADDR_SENSE_HI |=> regRdata == $past(senseHi_q))
    else $error("sense high readback");

  edge_start_a: assert property (@(posedge mclk) disable iff (!nrst)
    !flash_q && trigRise && !flashBlocked |=> flash_q)
    else $error("edge missed");

  edge_hold_a: assert property (@(posedge mclk) disable iff (!nrst)
    flash_q && !levelMode && !expired && !flashBlocked |=> flash_q)
    else $error("pulse cut short");

  edge_ignore_a: assert property (@(posedge mclk) disable iff (!nrst)
    flash_q && trigRise && !expired && !flashBlocked |=> cyc_q != 32'h0 || steps_q != 5'h00)
    else $error("pulse timer restarted");

  dur_step_a: assert property (@(posedge mclk) disable iff (!nrst)
    flash_q && cyc_q == STEP_CYCLES - 1 |=> steps_q == $past(steps_q) + 5'h01)
    else $error("duration step missed");

  done_flag_a: assert property (@(posedge mclk) disable iff (!nrst)
    evFlashDone |=> status_q[ST_FLASH_DONE] && !flash_q)
    else $error("timed pulse not ended");

  level_start_a: assert property (@(posedge mclk) disable iff (!nrst)
    !flash_q && levelMode && trigRise && !flashBlocked && !regFlashReq
      |=> flash_q && !regFlash_q)
    else $error("level start missed");

  level_hold_a: assert property (@(posedge mclk) disable iff (!nrst)
    flash_q && levelMode && trig && !expired && !flashBlocked |=> flash_q)
    else $error("level flash dropped");

  level_off_a: assert property (@(posedge mclk) disable iff (!nrst)
    flash_q && levelMode && !regFlash_q && !trig |=> !flash_q)
    else $error("level hold");

  timeout_off_a: assert property (@(posedge mclk) disable iff (!nrst)
    flash_q && expired |=> !flash_q)
    else $error("duration overrun");

  level_timeout_a: assert property (@(posedge mclk) disable iff (!nrst)
    evTimeout |=> !flash_q && status_q[ST_TIMEOUT])
    else $error("timeout not recorded");

  reg_start_a: assert property (@(posedge mclk) disable iff (!nrst)
    !flash_q && regFlashReq && !flashBlocked |=> flash_q && regFlash_q)
    else $error("register flash missed");

  idle_stay_a: assert property (@(posedge mclk) disable iff (!nrst)
    shutdown && !startReq |=> !flash_q)
    else $error("flash out of shutdown");

  ind_on_a: assert property (@(posedge mclk) disable iff (!nrst)
    regWr && regAddr == ADDR_GENERAL && regWdata[GP_IND_BIT] |=> indicatorCurrentOut)
    else $error("indicator not on");

  ind_off_a: assert property (@(posedge mclk) disable iff (!nrst)
    regWr && regAddr == ADDR_GENERAL && !regWdata[GP_IND_BIT] |=> !indicatorCurrentOut)
    else $error("indicator not off");

  gain_idle_a: assert property (@(posedge mclk) disable iff (!nrst)
    !charging |=> pumpGain == GAIN_1X)
    else $error("gain not reset");

  gain_step_a: assert property (@(posedge mclk) disable iff (!nrst)
    charging && gain_q == GAIN_1X && gainCnt_q == 8'hFF |=> pumpGain == GAIN_1P5X)
    else $error("gain stuck at lowest");

  gain_top_a: assert property (@(posedge mclk) disable iff (!nrst)
    charging && gain_q == GAIN_1P5X && gainCnt_q == 8'hFF |=> pumpGain == GAIN_2X)
    else $error("gain stuck at middle");

  eoc_event_a: assert property (@(posedge mclk) disable iff (!nrst)
    eoc_q && !eocPrev_q |=> status_q[ST_EOC])
    else $error("charge event not recorded");

  status_clear_a: assert property (@(posedge mclk) disable iff (!nrst)
    regWr && regAddr == ADDR_INT_CLR && regWdata[ST_BLOCKED] && !evBlocked
      |=> !status_q[ST_BLOCKED])
    else $error("status bit not cleared");

  status_read_a: assert property (@(posedge mclk) disable iff (!nrst)
    regRd && regAddr == ADDR_STATUS |=> regRdata == {4'h0, $past(status_q)})
    else $error("status readback");

  unmapped_read_a: assert property (@(posedge mclk) disable iff (!nrst)
    regRd && regAddr > ADDR_LIVE |=> regRdata == 8'h00)
    else $error("unmapped read not zero");

  read_idle_a: assert property (@(posedge mclk) disable iff (!nrst)
    !regRd |=> regRdata == 8'h00)
    else $error("read data outside its cycle");

endmodule : ftsc_flash_ctrl

/* logic/ftsc_pkg.sv */
/*
  Package for the flash trigger and sense control block: register offsets,
  field positions, reset values, timing constants and shared types.
  Assumes a 20 MHz system clock and a simple strobe register port.
*/
package ftsc_pkg;

  localparam int unsigned CLK_FREQ_HZ = 20_000_000;

  // Register offsets (register port address, 4 bits)
  localparam logic [3:0] ADDR_OPTIONS   = 4'h0;
  localparam logic [3:0] ADDR_GENERAL   = 4'h1;
  localparam logic [3:0] ADDR_SENSE_HI  = 4'h2;
  localparam logic [3:0] ADDR_SENSE_LO  = 4'h3;
  localparam logic [3:0] ADDR_STATUS    = 4'h4;
  localparam logic [3:0] ADDR_INT_EN    = 4'h5;
  localparam logic [3:0] ADDR_INT_CLR   = 4'h6;
  localparam logic [3:0] ADDR_LIVE      = 4'h7;

  // Options control register fields
  localparam int OPT_DUR_LSB   = 0;
  localparam int OPT_DUR_W     = 4;
  localparam int OPT_LEVEL_BIT = 7;

  // General purpose register fields
  localparam int GP_FLASH_BIT  = 0;
  localparam int GP_TORCH_BIT  = 1;
  localparam int GP_CHARGE_BIT = 2;
  localparam int GP_SENSE_BIT  = 6;
  localparam int GP_IND_BIT    = 7;

  // Reset values
  localparam logic [7:0] OPTIONS_RST  = 8'h00;
  localparam logic [7:0] GENERAL_RST  = 8'h00;
  localparam logic [7:0] SENSE_HI_RST = 8'hC0;
  localparam logic [7:0] SENSE_LO_RST = 8'h40;
  localparam logic [7:0] INT_EN_RST   = 8'h00;

  // Status / interrupt bit positions
  localparam int ST_FLASH_DONE = 0;
  localparam int ST_TIMEOUT    = 1;
  localparam int ST_BLOCKED    = 2;
  localparam int ST_EOC        = 3;
  localparam int ST_W          = 4;

  // One duration step of the flash timer, in microseconds
  localparam int unsigned DUR_STEP_US     = 32;
  localparam int unsigned DUR_STEP_CYCLES = (DUR_STEP_US * (CLK_FREQ_HZ / 1_000_000));

  // End-of-charge threshold (percent of target voltage) and middle-region flash scale (percent)
  localparam int unsigned EOC_PERCENT = 95;
  localparam int unsigned SCALE_MID_PERCENT = 70;

  typedef enum logic [1:0] {
    REGION_LOW,
    REGION_MID,
    REGION_HIGH
  } ftsc_region_type;

  typedef enum logic [1:0] {
    GAIN_1X,
    GAIN_1P5X,
    GAIN_2X
  } ftsc_gain_type;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } ftsc_bus_type;

endpackage : ftsc_pkg

/* sim/ftsc_host_model.sv */
/*
  Host model: a camera controller that drives the flash trigger pin.
  Assumes the bench calls fire() from its own sequence, one call at a time.
*/
`timescale 1ns/1ps
module ftsc_host_model (
  input  wire logic mclk,
  output logic      triggerIn
);
  initial triggerIn = 1'b0;
  // Push-pull pin, so it is never left floating between pulses
  task automatic fire(input int hold);
    @(posedge mclk);
    triggerIn <= 1'b1;
    repeat (hold) @(posedge mclk);
    triggerIn <= 1'b0;
  endtask : fire
endmodule : ftsc_host_model

/* sim/ftsc_flash_ctrl_bench.sv */
/*
  Bench for the flash control block: register tasks, trigger stimulus, checks.
  Assumes the host model drives the trigger and a pull-up sits on the flag pin.
*/
`timescale 1ns/1ps
module ftsc_flash_ctrl_bench;
  import ftsc_pkg::*;
  localparam int STEP = 4;
  logic       mclk = 1'b0, nrst, regWr, regRd;
  logic [3:0] regAddr;
  logic [7:0] regWdata, regRdata, v;
  logic       senseAboveHi, senseAboveLo, capAtTarget, capAbove95;
  logic       triggerIn, chargeDoneOut, chargeDoneOe, flashOn, indicatorCurrentOut;
  logic       shutdown, irq;
  logic [6:0] flashScalePct;
  logic [1:0] pumpGain;
  wire        eocPin = chargeDoneOe ? chargeDoneOut : 1'b1;
  int         errorCnt = 0, cmpCount = 0, cyc = 0, w;

  ftsc_flash_ctrl #(.STEP_CYCLES(STEP)) u_ftsc_flash_ctrl (.mclk(mclk), .nrst(nrst),
    .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata), .triggerIn(triggerIn), .senseAboveHi(senseAboveHi),
    .senseAboveLo(senseAboveLo), .capAtTarget(capAtTarget), .capAbove95(capAbove95),
    .chargeDoneOut(chargeDoneOut), .chargeDoneOe(chargeDoneOe), .flashOn(flashOn),
    .flashScalePct(flashScalePct), .indicatorCurrentOut(indicatorCurrentOut),
    .pumpGain(pumpGain), .shutdown(shutdown), .irq(irq));
  ftsc_host_model u_ftsc_host_model (.mclk(mclk), .triggerIn(triggerIn));

  always #25 mclk = ~mclk;

  task automatic completeRun;
    $display("comparisons %0d mismatches %0d", cmpCount, errorCnt);
    if (errorCnt == 0 && cmpCount > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : completeRun

  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      errorCnt++;
      completeRun();
    end
  end

  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    cmpCount++;
    if (g !== e) begin
      errorCnt++;
      $display("unexpected %s expected %0h seen %0h", n, e, g);
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge mclk);
    regWr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge mclk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge mclk);
    regRd <= 1'b0;
    @(negedge mclk);
    d = regRdata;
  endtask : rd

  task automatic tick(input int n);
    repeat (n) @(negedge mclk);
  endtask : tick

  // Bounded wait for the pulse, then its length in cycles
  task automatic measure(output int n);
    int t;
    n = 0;
    t = 0;
    while (flashOn !== 1'b1 && t < 20) begin
      @(negedge mclk);
      t++;
    end
    while (flashOn === 1'b1 && n < 300) begin
      @(negedge mclk);
      n++;
    end
  endtask : measure

  initial begin
    nrst <= 1'b0;
    {regWr, regRd, regAddr, regWdata} <= '0;
    {senseAboveHi, senseAboveLo, capAtTarget, capAbove95} <= '0;
    repeat (20) @(posedge mclk);
    nrst <= 1'b1;
    tick(2);
    chk("shutdown", 8'h01, 8'(shutdown));
    chk("scale", 8'h64, 8'(flashScalePct));
    rd(ADDR_OPTIONS, v);
    chk("options", OPTIONS_RST, v);
    rd(ADDR_SENSE_HI, v);
    chk("sense high", SENSE_HI_RST, v);
    rd(ADDR_SENSE_LO, v);
    chk("sense low", SENSE_LO_RST, v);
    rd(4'h8, v);
    chk("unmapped", 8'h00, v);
    wr(ADDR_OPTIONS, 8'h02);
    fork u_ftsc_host_model.fire(2); measure(w); join
    chk("edge pulse", 8'(3 * STEP), 8'(w));
    fork
      begin
        u_ftsc_host_model.fire(2);
        repeat (4) @(posedge mclk);
        u_ftsc_host_model.fire(2);
      end
      measure(w);
    join
    chk("retrigger", 8'(3 * STEP), 8'(w));
    fork wr(ADDR_GENERAL, 8'h01); measure(w); join
    chk("register flash", 8'(3 * STEP), 8'(w));
    wr(ADDR_OPTIONS, 8'h8F);
    fork u_ftsc_host_model.fire(6); measure(w); join
    chk("level pulse", 8'h06, 8'(w));
    wr(ADDR_OPTIONS, 8'h81);
    fork u_ftsc_host_model.fire(30); measure(w); join
    chk("level expiry", 8'(2 * STEP), 8'(w));
    rd(ADDR_STATUS, v);
    chk("timeout flag", 8'h01, 8'(v[ST_TIMEOUT]));
    wr(ADDR_GENERAL, 8'h40);
    senseAboveLo <= 1'b1;
    tick(6);
    chk("mid scale", 8'(SCALE_MID_PERCENT), 8'(flashScalePct));
    wr(ADDR_INT_EN, 8'h04);
    senseAboveHi <= 1'b1;
    fork u_ftsc_host_model.fire(2); measure(w); join
    chk("blocked", 8'h00, 8'(w));
    chk("irq set", 8'h01, 8'(irq));
    wr(ADDR_INT_EN, 8'h00);
    tick(2);
    chk("irq masked", 8'h00, 8'(irq));
    wr(ADDR_INT_EN, 8'h04);
    wr(ADDR_INT_CLR, 8'h04);
    tick(2);
    chk("irq cleared", 8'h00, 8'(irq));
    wr(ADDR_GENERAL, 8'h00);
    wr(ADDR_OPTIONS, 8'h02);
    fork u_ftsc_host_model.fire(2); measure(w); join
    chk("sense off", 8'(3 * STEP), 8'(w));
    wr(ADDR_GENERAL, 8'h80);
    senseAboveHi <= 1'b0;
    senseAboveLo <= 1'b0;
    tick(2);
    chk("indicator on", 8'h01, 8'(indicatorCurrentOut));
    wr(ADDR_GENERAL, 8'h04);
    tick(2);
    chk("indicator off", 8'h00, 8'(indicatorCurrentOut));
    chk("awake", 8'h00, 8'(shutdown));
    tick(520);
    chk("pump gain", 8'(GAIN_2X), 8'(pumpGain));
    chk("flag idle", 8'h01, 8'(eocPin));
    @(posedge mclk);
    capAtTarget <= 1'b1;
    capAbove95 <= 1'b1;
    tick(5);
    chk("flag done", 8'h00, 8'(eocPin));
    chk("flag drive", 8'h01, 8'(chargeDoneOe));
    chk("flag level", 8'h00, 8'(chargeDoneOut));
    rd(ADDR_LIVE, v);
    chk("live", 8'h40, v);
    @(posedge mclk);
    capAtTarget <= 1'b0;
    tick(5);
    chk("flag hold", 8'h00, 8'(eocPin));
    @(posedge mclk);
    capAbove95 <= 1'b0;
    tick(5);
    chk("flag droop", 8'h01, 8'(eocPin));
    completeRun();
  end
endmodule : ftsc_flash_ctrl_bench
